// ===== rtl/motor_startup_config_regs.sv
/*
 * motor start-up configuration bank: three 8-bit registers on an
 * avalon-mm slave with waitrequest, their decoded values, and the small
 * timers that apply them (stationary judgement, braking time, fixed
 * commutation advance, reverse/brake speed threshold).
 * assumes one 50 MHz clock, all inputs synchronous to it, and an
 * avalon master that holds its request until waitrequest is low.
 */
// Chosen here: the Avalon-MM interface to the registers.
// Behaviour
// - bit 7 of advance register: 0 fixed advance time, 1 speed/supply based
// - advance time is 2.5 us times significand shifted by shift count
// - stationary threshold codes give 80, 160, 320, 640 ms without crossing
// - post-sense advance angle codes give 30, 60, 90, 120 degrees
// - initial speed detection runs only when its enable bit is one
// - reverse drive happens only when its enable bit is one
// - reverse/brake speed threshold codes give 6.3, 13, 26, 51 Hz
// - open-loop current codes give 0.2, 0.4, 0.8, 1.6 A
// - open-loop ramp codes give 6 down to 0.023 supply per second
// - brake code 0 disables braking, others give 2.7 s down to 0.04 s
`timescale 1ns/1ps
module motor_startup_config_regs #(
   parameter int MS_CYCLES = motor_cfg_pkg::MS_CYC
) (
   input  wire logic                         clk_in,
   input  wire logic                         resetn_in,
   input  wire logic [motor_cfg_pkg::ADDR_W-1:0] address_in,
   input  wire logic                         read_in,
   input  wire logic                         write_in,
   input  wire logic [motor_cfg_pkg::BUS_W-1:0]  writedata_in,
   input  wire logic [3:0]                   byteenable_in,
   output logic [motor_cfg_pkg::BUS_W-1:0]   readdata_out,
   output logic                              waitrequest_out,
   input  wire logic                         zero_cross_in,
   input  wire logic [15:0]                  speed_dhz_in,
   input  wire logic                         brake_start_in,
   input  wire logic                         commutate_in,
   output motor_cfg_pkg::decoded_t           cfg_out,
   output logic                              stationary_out,
   output logic                              reverse_drive_req_out,
   output logic                              brake_req_out,
   output logic                              brake_active_out,
   output logic                              brake_done_out,
   output logic                              advance_fire_out
);
   import motor_cfg_pkg::*;

   // ********************************************************************
   // state of the whole block
   // ********************************************************************
   typedef struct packed {
      cfg_t         cfg;
      decoded_t     dec;
      bus_state_t   bus;
      logic         waitreq;
      logic [31:0]  rdata;
      logic [15:0]  ms_div;
      logic         ms_tick;
      logic [9:0]   stat_ms;
      logic         stationary;
      brake_state_t brk;
      logic [11:0]  brk_ms;
      logic         brk_active;
      logic         brk_done;
      logic [17:0]  adv_cnt;
      logic         adv_busy;
      logic         adv_fire;
      logic         rev_req;
      logic         brk_req;
   } state_t;

   localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
   localparam logic [9:0]  MS_ONE  = 10'h001;
   localparam logic [11:0] BRK_ONE = 12'h001;
   localparam logic [17:0] ADV_ONE = 18'h0_0001;

   state_t      state_r;
   state_t      state_nxt;
   logic [17:0] adv_cycles;
   decoded_t    dec_comb;

   // ********************************************************************
   // register decode shared by the read and write paths
   // ********************************************************************
   function automatic logic [1:0] reg_sel(input logic [7:0] addr);
      logic [1:0] sel;
      sel = 2'h0;
      case (addr)
         ADDR_ADV:  sel = 2'h1;
         ADDR_OPT1: sel = 2'h2;
         ADDR_OPT2: sel = 2'h3;
         default:   sel = 2'h0;
      endcase
      return sel;
   endfunction

   // ********************************************************************
   // field arithmetic and decoding
   // ********************************************************************
   advance_time_calc u_adv (
      .adv_in     (state_r.cfg.adv),
      .cycles_out (adv_cycles)
   );

   cfg_decode u_dec (
      .cfg_in        (state_r.cfg),
      .adv_cycles_in (adv_cycles),
      .dec_out       (dec_comb)
   );

   // ********************************************************************
   // next-state logic
   // ********************************************************************
   always_comb begin
      state_nxt = state_r;

      // decoded parameters follow the stored fields one cycle later
      state_nxt.dec = dec_comb;

      // bus slave: one wait cycle, then a single answer cycle
      case (state_r.bus)
         BUS_IDLE: begin
            state_nxt.waitreq = 1'b1;
            if (read_in || write_in) begin
               case (reg_sel(address_in))
                  2'h1:    state_nxt.rdata = {24'h00_0000, state_r.cfg.adv};
                  2'h2:    state_nxt.rdata = {24'h00_0000, state_r.cfg.opt1};
                  2'h3:    state_nxt.rdata = {24'h00_0000, state_r.cfg.opt2};
                  default: state_nxt.rdata = 32'h0000_0000;
               endcase
               state_nxt.waitreq = 1'b0;
               state_nxt.bus     = BUS_ACK;
            end
         end
         BUS_ACK: begin
            // write takes effect at the edge the master sees no wait
            if (write_in && byteenable_in[0]) begin
               case (reg_sel(address_in))
                  2'h1:    state_nxt.cfg.adv  = writedata_in[7:0];
                  2'h2:    state_nxt.cfg.opt1 = writedata_in[7:0];
                  2'h3:    state_nxt.cfg.opt2 = writedata_in[7:0];
                  default: state_nxt.cfg      = state_r.cfg;
               endcase
            end
            state_nxt.waitreq = 1'b1;
            state_nxt.bus     = BUS_IDLE;
         end
         default: begin
            state_nxt.waitreq = 1'b1;
            state_nxt.bus     = BUS_IDLE;
         end
      endcase

      // millisecond tick for the slow timers
      state_nxt.ms_tick = 1'b0;
      if (state_r.ms_div >= MS_LAST) begin
         state_nxt.ms_div  = 16'h0000;
         state_nxt.ms_tick = 1'b1;
      end else begin
         state_nxt.ms_div = state_r.ms_div + 16'h0001;
      end

      // stationary judgement: time since last zero crossing
      if (!state_r.dec.initial_speed_detect_enable) begin
         state_nxt.stat_ms    = 10'h000;
         state_nxt.stationary = 1'b0;
      end else if (zero_cross_in) begin
         state_nxt.stat_ms    = 10'h000;
         state_nxt.stationary = 1'b0;
      end else begin
         if (state_r.ms_tick &&
             state_r.stat_ms < state_r.dec.stationary_ms) begin
            state_nxt.stat_ms = state_r.stat_ms + MS_ONE;
         end
         state_nxt.stationary =
            (state_r.stat_ms >= state_r.dec.stationary_ms);
      end

      // speed at or above threshold asks for reverse drive, or for braking when reverse is off and braking is enabled
      state_nxt.rev_req = state_r.dec.reverse_drive_enable &&
         (speed_dhz_in >= 16'(state_r.dec.reverse_thr_dhz));
      state_nxt.brk_req = !state_r.dec.reverse_drive_enable &&
         state_r.dec.brake_enable &&
         (speed_dhz_in >= 16'(state_r.dec.reverse_thr_dhz));

      // braking timer
      state_nxt.brk_done = 1'b0;
      case (state_r.brk)
         BRK_IDLE: begin
            if (brake_start_in && state_r.dec.brake_enable) begin
               state_nxt.brk_ms     = state_r.dec.brake_ms;
               state_nxt.brk_active = 1'b1;
               state_nxt.brk        = BRK_RUN;
            end
         end
         BRK_RUN: begin
            if (state_r.ms_tick) begin
               if (state_r.brk_ms <= BRK_ONE) begin
                  state_nxt.brk_ms     = 12'h000;
                  state_nxt.brk_active = 1'b0;
                  state_nxt.brk_done   = 1'b1;
                  state_nxt.brk        = BRK_DONE;
               end else begin
                  state_nxt.brk_ms = state_r.brk_ms - BRK_ONE;
               end
            end
         end
         BRK_DONE: begin
            state_nxt.brk = BRK_IDLE;
         end
         default: begin
            state_nxt.brk_active = 1'b0;
            state_nxt.brk        = BRK_IDLE;
         end
      endcase

      // fixed commutation advance: delay a commutation by the set time
      state_nxt.adv_fire = 1'b0;
      if (commutate_in && !state_r.dec.advance_method_select) begin
         if (state_r.dec.advance_time_value == 18'h0_0000) begin
            state_nxt.adv_fire = 1'b1;
            state_nxt.adv_busy = 1'b0;
         end else begin
            state_nxt.adv_cnt  = state_r.dec.advance_time_value;
            state_nxt.adv_busy = 1'b1;
         end
      end else if (state_r.adv_busy) begin
         if (state_r.adv_cnt <= ADV_ONE) begin
            state_nxt.adv_cnt  = 18'h0_0000;
            state_nxt.adv_busy = 1'b0;
            state_nxt.adv_fire = 1'b1;
         end else begin
            state_nxt.adv_cnt = state_r.adv_cnt - ADV_ONE;
         end
      end
      // variable mode hands timing to the engine; drop pending work
      if (state_r.dec.advance_method_select) begin
         state_nxt.adv_busy = 1'b0;
         state_nxt.adv_fire = 1'b0;
      end
   end

   // ********************************************************************
   // state register
   // ********************************************************************
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_r            <= '0;
         state_r.cfg.adv    <= RST_ADV;
         state_r.cfg.opt1   <= RST_OPT1;
         state_r.cfg.opt2   <= RST_OPT2;
         state_r.bus        <= BUS_IDLE;
         state_r.waitreq    <= 1'b1;
         state_r.brk        <= BRK_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ********************************************************************
   // outputs, all straight from the state register
   // ********************************************************************
   assign readdata_out          = state_r.rdata;
   assign waitrequest_out       = state_r.waitreq;
   assign cfg_out               = state_r.dec;
   assign stationary_out        = state_r.stationary;
   assign reverse_drive_req_out = state_r.rev_req;
   assign brake_req_out         = state_r.brk_req;
   assign brake_active_out      = state_r.brk_active;
   assign brake_done_out        = state_r.brk_done;
   assign advance_fire_out      = state_r.adv_fire;

endmodule

// ===== rtl/motor_cfg_pkg.sv
/*
 * shared constants and types for the motor start-up configuration bank:
 * register indices and byte addresses, field layouts, reset values,
 * decode tables, timing constants and state encodings.
 * assumes a single 50 MHz clock and a 32-bit avalon-mm register bus.
 */
package motor_cfg_pkg;

   // ********************************************************************
   // timing
   // ********************************************************************
   localparam int CLK_NS      = 20;      // 50 MHz clock period
   localparam int ADV_UNIT_NS = 2500;    // advance step of 2.5 us
   localparam int ADV_UNIT_CYC = (ADV_UNIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int MS_NS       = 1000000; // one millisecond
   localparam int MS_CYC      = MS_NS / CLK_NS;

   // ********************************************************************
   // register map (index times four is the byte address)
   // ********************************************************************
   localparam int         BUS_W    = 32;
   localparam int         ADDR_W   = 8;
   localparam logic [7:0] IDX_ADV  = 8'h22;
   localparam logic [7:0] IDX_OPT1 = 8'h23;
   localparam logic [7:0] IDX_OPT2 = 8'h24;
   localparam logic [7:0] ADDR_ADV  = {IDX_ADV[5:0], 2'b00};
   localparam logic [7:0] ADDR_OPT1 = {IDX_OPT1[5:0], 2'b00};
   localparam logic [7:0] ADDR_OPT2 = {IDX_OPT2[5:0], 2'b00};
   localparam logic [7:0] RST_ADV   = 8'h00;
   localparam logic [7:0] RST_OPT1  = 8'h00;
   localparam logic [7:0] RST_OPT2  = 8'h00;

   // ********************************************************************
   // field layouts
   // ********************************************************************
   typedef struct packed {
      logic       advance_method_select; // 0 fixed, 1 speed/supply based
      logic [2:0] shift;                 // advance_time_field shift count
      logic [3:0] sig;                   // advance_time_field significand
   } adv_reg_t;

   typedef struct packed {
      logic [1:0] stationary_threshold;
      logic [1:0] post_sense_advance_angle;
      logic       initial_speed_detect_enable;
      logic       reverse_drive_enable;
      logic [1:0] reverse_drive_threshold;
   } opt1_reg_t;

   typedef struct packed {
      logic [1:0] open_loop_current;
      logic [2:0] open_loop_ramp_rate;
      logic [2:0] brake_duration;
   } opt2_reg_t;

   typedef struct packed {
      adv_reg_t  adv;
      opt1_reg_t opt1;
      opt2_reg_t opt2;
   } cfg_t;

   // decoded operating parameters handed to the motor-control engine
   typedef struct packed {
      logic        advance_method_select;
      logic [17:0] advance_time_value;    // clock cycles
      logic [9:0]  stationary_ms;
      logic [6:0]  advance_angle_deg;
      logic        initial_speed_detect_enable;
      logic        reverse_drive_enable;
      logic [8:0]  reverse_thr_dhz;       // units of 0.1 Hz
      logic [4:0]  open_loop_current_da;  // units of 0.1 A
      logic [12:0] ramp_mvcc_s;           // units of 0.001 supply/s
      logic        brake_enable;
      logic [11:0] brake_ms;
   } decoded_t;

   // ********************************************************************
   // decode tables, entry 0 in the low slot
   // ********************************************************************
   localparam logic [3:0][9:0] STAT_MS_TBL =
      {10'h280, 10'h140, 10'h0a0, 10'h050};           // 640..80 ms
   localparam logic [3:0][6:0] ANGLE_TBL =
      {7'h78, 7'h5a, 7'h3c, 7'h1e};                   // 120..30 deg
   localparam logic [3:0][8:0] REV_THR_TBL =
      {9'h1fe, 9'h104, 9'h082, 9'h03f};               // 51..6.3 Hz
   localparam logic [3:0][4:0] CURR_TBL =
      {5'h10, 5'h08, 5'h04, 5'h02};                   // 1.6..0.2 A
   localparam logic [7:0][12:0] RAMP_TBL =
      {13'h0017, 13'h0046, 13'h00a0, 13'h0154,
       13'h02bc, 13'h05dc, 13'h0bb8, 13'h1770};       // 0.023..6
   localparam logic [7:0][11:0] BRAKE_TBL =
      {12'h028, 12'h050, 12'h0a0, 12'h14a,
       12'h29e, 12'h514, 12'ha8c, 12'h000};           // 0.04..2.7 s
   localparam logic [2:0] BRAKE_OFF = 3'h0;

   // ********************************************************************
   // state encodings
   // ********************************************************************
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_t;

   typedef enum logic [2:0] {
      BRK_IDLE = 3'b001,
      BRK_RUN  = 3'b010,
      BRK_DONE = 3'b100
   } brake_state_t;

endpackage

// ===== rtl/advance_time_calc.sv
/*
 * converts the packed advance delay field into a count of clock cycles.
 * assumes the field is stable while used; purely combinational.
 */
`timescale 1ns/1ps
module advance_time_calc (
   input  wire motor_cfg_pkg::adv_reg_t adv_in,
   output logic [17:0]                  cycles_out
);
   import motor_cfg_pkg::*;

   logic [10:0] steps;

   // ********************************************************************
   // significand shifted by the shift count, times the 2.5 us step
   // ********************************************************************
   always_comb begin
      steps      = 11'(adv_in.sig) << adv_in.shift;
      cycles_out = 18'(32'(steps) * ADV_UNIT_CYC);
   end

endmodule

// ===== rtl/cfg_decode.sv
/*
 * decodes the three configuration registers into operating values.
 * assumes its inputs come from flip-flops; purely combinational.
 */
`timescale 1ns/1ps
module cfg_decode (
   input  wire motor_cfg_pkg::cfg_t cfg_in,
   input  wire logic [17:0]         adv_cycles_in,
   output motor_cfg_pkg::decoded_t  dec_out
);
   import motor_cfg_pkg::*;

   // ********************************************************************
   // table lookups per field
   // ********************************************************************
   always_comb begin
      dec_out = '0;
      dec_out.advance_method_select =
         cfg_in.adv.advance_method_select;
      dec_out.advance_time_value = adv_cycles_in;
      dec_out.stationary_ms =
         STAT_MS_TBL[cfg_in.opt1.stationary_threshold];
      dec_out.advance_angle_deg =
         ANGLE_TBL[cfg_in.opt1.post_sense_advance_angle];
      dec_out.initial_speed_detect_enable =
         cfg_in.opt1.initial_speed_detect_enable;
      dec_out.reverse_drive_enable =
         cfg_in.opt1.reverse_drive_enable;
      dec_out.reverse_thr_dhz =
         REV_THR_TBL[cfg_in.opt1.reverse_drive_threshold];
      dec_out.open_loop_current_da =
         CURR_TBL[cfg_in.opt2.open_loop_current];
      dec_out.ramp_mvcc_s =
         RAMP_TBL[cfg_in.opt2.open_loop_ramp_rate];
      dec_out.brake_enable =
         (cfg_in.opt2.brake_duration != BRAKE_OFF);
      dec_out.brake_ms = BRAKE_TBL[cfg_in.opt2.brake_duration];
   end

endmodule

// ===== bench/motor_engine_model.sv
/* engine-side model: drives speed and the one-cycle event strobes.
   assumes the bench calls its tasks just after a rising edge. */
`timescale 1ns/1ps
module motor_engine_model (
   input  wire logic  clk_in,
   output logic       zero_cross_out,
   output logic [15:0] speed_dhz_out,
   output logic       brake_start_out,
   output logic       commutate_out
);
   // idle engine: no events, motor at rest
   initial begin
      zero_cross_out = 1'b0;
      speed_dhz_out = 16'h0000;
      brake_start_out = 1'b0;
      commutate_out = 1'b0;
   end
   // one-cycle strobe: 0 zero cross, 1 brake start, else commutation
   task automatic strobe(input int which);
      @(posedge clk_in);
      case (which)
         0: zero_cross_out <= 1'b1;
         1: brake_start_out <= 1'b1;
         default: commutate_out <= 1'b1;
      endcase
      @(posedge clk_in);
      {zero_cross_out, brake_start_out, commutate_out} <= 3'b000;
   endtask
   // speed in tenths of hertz, held until changed
   task automatic set_speed(input logic [15:0] v);
      @(posedge clk_in);
      speed_dhz_out <= v;
   endtask
endmodule

// ===== bench/motor_startup_config_regs_assertions.sv
/* concurrent checks on the configuration bank's ports.
   assumes one clock domain; bound to the bank at the foot. */
`timescale 1ns/1ps
module motor_cfg_checker
   import motor_cfg_pkg::*;
(
   input wire logic              clk_in,
   input wire logic              resetn_in,
   input wire logic [ADDR_W-1:0] address_in,
   input wire logic              write_in,
   input wire logic [BUS_W-1:0]  writedata_in,
   input wire logic [3:0]        byteenable_in,
   input wire logic              waitrequest_out,
   input wire decoded_t          cfg_out,
   input wire logic              stationary_out,
   input wire logic              reverse_drive_req_out,
   input wire logic              brake_active_out,
   input wire logic              brake_done_out,
   input wire logic              advance_fire_out
);
   // accepted writes per register and their low byte
   wire       wr_ok = !waitrequest_out && write_in && byteenable_in[0];
   wire [7:0] wd = writedata_in[7:0];
   wire       adv_wr = wr_ok && address_in == ADDR_ADV;
   wire       op1_wr = wr_ok && address_in == ADDR_OPT1;
   wire       op2_wr = wr_ok && address_in == ADDR_OPT2;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // ********
   // properties
   // ********
   wait_one_a: assert property (!waitrequest_out |=> waitrequest_out)
      else $error("answer cycle longer than one clock");
   adv_method_a: assert property (adv_wr |-> ##2
      cfg_out.advance_method_select == $past(wd[7], 2))
      else $error("advance method not applied");
   adv_time_a: assert property (adv_wr |-> ##2
      cfg_out.advance_time_value ==
      18'(125 * (32'($past(wd[3:0], 2)) << $past(wd[6:4], 2))))
      else $error("advance time not decoded");
   stat_ms_a: assert property (op1_wr |-> ##2
      cfg_out.stationary_ms == 10'(80 << $past(wd[7:6], 2)))
      else $error("stationary time not decoded");
   angle_dec_a: assert property (op1_wr |-> ##2
      cfg_out.advance_angle_deg == 7'(30 * (32'($past(wd[5:4], 2)) + 1)))
      else $error("advance angle not decoded");
   brake_en_a: assert property (op2_wr |-> ##2
      cfg_out.brake_enable == ($past(wd[2:0], 2) != 3'h0))
      else $error("brake enable not decoded");
   isd_off_a: assert property (
      !cfg_out.initial_speed_detect_enable [*3] |-> !stationary_out)
      else $error("stationary flag while detection off");
   rev_off_a: assert property (
      !cfg_out.reverse_drive_enable [*3] |-> !reverse_drive_req_out)
      else $error("reverse request while reverse off");
   brake_end_a: assert property ($fell(brake_active_out) |-> brake_done_out)
      else $error("braking ended without done pulse");
   fire_pulse_a: assert property (advance_fire_out |=> !advance_fire_out)
      else $error("advance pulse longer than one clock");
   // main scenarios reached
   cover property (adv_wr);
   cover property (brake_done_out);
   cover property (advance_fire_out);
endmodule
bind motor_startup_config_regs motor_cfg_checker chk (
   .clk_in(clk_in), .resetn_in(resetn_in), .address_in(address_in),
   .write_in(write_in), .writedata_in(writedata_in),
   .byteenable_in(byteenable_in), .waitrequest_out(waitrequest_out),
   .cfg_out(cfg_out), .stationary_out(stationary_out),
   .reverse_drive_req_out(reverse_drive_req_out),
   .brake_active_out(brake_active_out), .brake_done_out(brake_done_out),
   .advance_fire_out(advance_fire_out));

// ===== bench/motor_startup_config_regs_tb_top.sv
/* self-checking bench for the configuration bank.
   assumes the engine model file and the bound checker. */
`timescale 1ns/1ps
module motor_startup_config_regs_tb_top;
   import motor_cfg_pkg::*;
   localparam int MSC = 10; // short millisecond for simulation
   logic        clk_in, resetn_in, read_in, write_in, waitrequest_out;
   logic [7:0]  address_in;
   logic [31:0] writedata_in, readdata_out, q;
   logic [3:0]  byteenable_in;
   logic [15:0] spd;
   logic        zc, bs, cm, stat, rev, brq, bact, bdone, fire;
   decoded_t    cfg;
   int          miscompares, cmp_count, n;
   int          rt[4] = '{63, 130, 260, 510};
   int          rp[8] = '{6000, 3000, 1500, 700, 340, 160, 70, 23};
   int          bk[8] = '{0, 2700, 1300, 670, 330, 160, 80, 40};
   wire [3:0]   ev = {!waitrequest_out, stat, fire, bdone};
   motor_startup_config_regs #(.MS_CYCLES(MSC)) uut (
      .clk_in(clk_in), .resetn_in(resetn_in), .address_in(address_in),
      .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
      .byteenable_in(byteenable_in), .readdata_out(readdata_out),
      .waitrequest_out(waitrequest_out), .zero_cross_in(zc),
      .speed_dhz_in(spd), .brake_start_in(bs), .commutate_in(cm),
      .cfg_out(cfg), .stationary_out(stat), .reverse_drive_req_out(rev),
      .brake_req_out(brq), .brake_active_out(bact),
      .brake_done_out(bdone), .advance_fire_out(fire));
   motor_engine_model eng (
      .clk_in(clk_in), .zero_cross_out(zc), .speed_dhz_out(spd),
      .brake_start_out(bs), .commutate_out(cm));
   // ********
   // tasks
   // ********
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic rd, input logic [7:0] a,
                      input logic [7:0] d, input logic [3:0] be,
                      output logic [31:0] r);
      int t;
      @(posedge clk_in);
      address_in <= a;
      writedata_in <= {4{d}};
      byteenable_in <= be;
      read_in <= rd;
      write_in <= !rd;
      wait_for(3, 40, t); // waitrequest low
      r = readdata_out;
      read_in <= 1'b0;
      write_in <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b0, a, d, 4'h1, r);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      bus(1'b1, a, 8'h00, 4'hf, q);
      cmp(q, {24'h0000_00, e});
   endtask
   // let a registered update land
   task automatic settle;
      repeat (2) @(negedge clk_in);
   endtask
   // count cycles until the chosen event flag is seen, up to a bound
   task automatic wait_for(input int k, input int lim, output int m);
      m = 0;
      do begin
         @(posedge clk_in);
         m++;
      end while (ev[k] !== 1'b1 && m < lim);
      if (ev[k] !== 1'b1) begin
         miscompares++;
         tally_and_finish;
      end
   endtask
   // free-running clock and the hang limit
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      repeat (100000) @(posedge clk_in);
      miscompares++;
      tally_and_finish;
   end
   // ********
   // main sequence
   // ********
   initial begin
      {resetn_in, read_in, write_in} = 3'b000;
      address_in = 8'h00;
      writedata_in = 32'h0000_0000;
      byteenable_in = 4'h0;
      repeat (5) @(posedge clk_in);
      resetn_in <= 1'b1;
      rdc(ADDR_ADV, RST_ADV);
      rdc(ADDR_OPT1, RST_OPT1);
      rdc(ADDR_OPT2, RST_OPT2);
      bus(1'b0, ADDR_ADV, 8'h5a, 4'he, q);
      bus(1'b0, 8'h94, 8'hff, 4'hf, q);
      rdc(ADDR_ADV, 8'h00);
      rdc(8'h94, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_OPT1, {c[1:0], c[1:0], 2'b11, c[1:0]});
         settle();
         cmp(cfg.stationary_ms, 80 << c);
         cmp(cfg.advance_angle_deg, 30 * (c + 1));
         cmp(cfg.reverse_thr_dhz, rt[c]);
         cmp(cfg.initial_speed_detect_enable, 1);
         cmp(cfg.reverse_drive_enable, 1);
         rdc(ADDR_OPT1, {c[1:0], c[1:0], 2'b11, c[1:0]});
      end
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_OPT2, {c[1:0], c[2:0], c[2:0]});
         settle();
         cmp(cfg.open_loop_current_da, 2 << c[1:0]);
         cmp(cfg.ramp_mvcc_s, rp[c]);
         cmp(cfg.brake_ms, bk[c]);
         cmp(cfg.brake_enable, c != 0);
      end
      // fixed advance of 4 shifted by 1 steps, then the variable mode
      wr(ADDR_ADV, 8'h14);
      settle();
      cmp(cfg.advance_time_value, 1000);
      eng.strobe(2);
      wait_for(1, 1100, n);
      cmp(n >= 995 && n <= 1003, 1);
      wr(ADDR_ADV, 8'hc1);
      settle();
      cmp(cfg.advance_time_value, 2000);
      cmp(cfg.advance_method_select, 1);
      eng.strobe(2);
      n = 0;
      repeat (2500) @(negedge clk_in) n += (fire !== 1'b0);
      cmp(n, 0);
      // reverse against brake around the lowest threshold
      wr(ADDR_OPT1, 8'h04);
      wr(ADDR_OPT2, 8'h07);
      eng.set_speed(16'h003f);
      settle();
      cmp({rev, brq}, 2'b10);
      eng.set_speed(16'h003e);
      settle();
      cmp({rev, brq}, 2'b00);
      wr(ADDR_OPT1, 8'h00);
      eng.set_speed(16'h003f);
      settle();
      cmp({rev, brq}, 2'b01);
      eng.strobe(1);
      @(negedge clk_in);
      cmp(bact, 1);
      wait_for(0, 500, n);
      cmp(n >= 385 && n <= 405, 1);
      wr(ADDR_OPT2, 8'h00);
      settle();
      eng.strobe(1);
      @(negedge clk_in);
      cmp({bact, brq}, 2'b00);
      // stationary judgement after a zero crossing
      wr(ADDR_OPT1, 8'h08);
      settle();
      eng.strobe(0);
      repeat (700) @(negedge clk_in);
      cmp(stat, 0);
      wait_for(2, 200, n);
      cmp(stat, 1);
      wr(ADDR_OPT1, 8'h00);
      repeat (2) settle();
      cmp(stat, 0);
      // second reset in mid-run clears the bank
      @(posedge clk_in);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      rdc(ADDR_ADV, RST_ADV);
      tally_and_finish;
   end
endmodule
